// ==== psm_pkg.sv ====
package psm_pkg;

  // register offsets in the memory map
  localparam logic [11:0] PSM_ADDR_CONTROL     = 12'h0270;
  localparam logic [11:0] PSM_ADDR_PERIOD_LO   = 12'h0271;
  localparam logic [11:0] PSM_ADDR_PERIOD_MID  = 12'h0272;
  localparam logic [11:0] PSM_ADDR_PERIOD_HI   = 12'h0273;
  localparam logic [11:0] PSM_ADDR_PEAK_LO     = 12'h0274;
  localparam logic [11:0] PSM_ADDR_PEAK_HI     = 12'h0275;
  localparam logic [11:0] PSM_ADDR_LINK_EN_A   = 12'h0279;
  localparam logic [11:0] PSM_ADDR_LINK_EN_B   = 12'h027a;
  localparam logic [11:0] PSM_ADDR_CBIT_SEL_A  = 12'h0559;
  localparam logic [11:0] PSM_ADDR_CBIT_SEL_B  = 12'h055a;
  localparam logic [11:0] PSM_ADDR_CBIT_COUNT  = 12'h058f;

  // field positions
  localparam int PSM_CTRL_PEAK_EN_BIT  = 1;
  localparam int PSM_LINK_EN_B_BIT     = 1;
  localparam logic [1:0] PSM_LINK_EN_A_MASK = 2'h3;

  // widths
  localparam int PSM_PERIOD_W = 24;
  localparam int PSM_PEAK_W   = 13;
  localparam int PSM_FRAME_W  = 25;
  localparam int PSM_CBIT_MAX = 3;

  // reset values
  localparam logic [7:0]  PSM_REG_RESET    = 8'h00;
  localparam logic [23:0] PSM_PERIOD_RESET = 24'h00_0000;
  localparam logic [12:0] PSM_PEAK_RESET   = 13'h0000;

  // frame fields
  localparam logic [4:0] PSM_ID_SUBFRAME = 5'h01;   // start 0, identifier 0001
  localparam logic       PSM_START_BIT   = 1'b0;
  localparam logic [2:0] PSM_LSB_PAD     = 3'h0;
  localparam logic       PSM_IDLE_BIT    = 1'b1;

  // one converter sample with its strobe
  typedef struct packed {
    logic        valid;
    logic [13:0] data;
  } psm_sample_type;

  // transmitted word: sample with control bits below its lsb
  typedef struct packed {
    logic        valid;
    logic [16:0] word;
  } psm_word_type;

  // register access port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } psm_reg_req_type;

endpackage

// ==== psm_peak_monitor.sv ====
`timescale 1ns/100ps
// Contract
// - 24-bit period sets measurement length
// - track magnitude only, 13-bit peak
// - control monitor_control bit 1 enables detection
// - load period, decrement per decimated sample
// - keep larger of magnitude and running max
// - seed running max with current sample
// - at count 1 copy peak to holding
// - reload timer, reseed max from next sample
// - link embed needs monitor_link_enable_a[1:0], monitor_link_enable_b[1]
// - control bits filled from msb downward
// - 25-bit frame, msb first, five subframes
// - start 0, id, peak nibbles, idle ones
// - control bits appended below sample lsb
module psm_peak_monitor
  import psm_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            reset,
  input  wire psm_sample_type  sample_in,
  input  wire psm_reg_req_type reg_req,
  output logic [7:0]           reg_rdata,
  output psm_word_type         word_out,
  output logic                 peak_update
);

  typedef enum logic [1:0] {
    PSM_TX_IDLE,
    PSM_TX_SEND
  } psm_tx_state_type;

  // magnitude of a signed sample, saturated to the peak width
  function automatic logic [PSM_PEAK_W-1:0] psm_mag(input logic [13:0] s);
    logic [13:0] a;
    a = s[13] ? 14'((~s) + 14'h0001) : s;
    psm_mag = a[13] ? {PSM_PEAK_W{1'b1}} : a[PSM_PEAK_W-1:0];
  endfunction

  logic [7:0]              control_r;
  logic [7:0]              link_en_a_r;
  logic [7:0]              link_en_b_r;
  logic [7:0]              cbit_sel_a_r;
  logic [7:0]              cbit_sel_b_r;
  logic [7:0]              cbit_count_r;
  logic [PSM_PERIOD_W-1:0] period_r;
  logic [PSM_PERIOD_W-1:0] timer_r;
  logic [PSM_PEAK_W-1:0]   run_max_r;
  logic [PSM_PEAK_W-1:0]   holding_r;
  logic                    seed_r;
  logic                    enabled_r;
  logic                    frame_pending_r;
  logic [PSM_FRAME_W-1:0]  shift_r;
  logic [4:0]              bit_cnt_r;
  psm_tx_state_type        tx_state_r;

  logic                    peak_en;
  logic                    link_en;
  logic [PSM_PEAK_W-1:0]   cur_mag;
  logic [PSM_PEAK_W-1:0]   cur_peak;
  logic                    period_end;
  logic                    mon_bit;
  logic [PSM_CBIT_MAX-1:0] cbits;

  // decoded enables and running comparison
  assign peak_en    = control_r[PSM_CTRL_PEAK_EN_BIT];
  assign link_en    = ((link_en_a_r[1:0] & PSM_LINK_EN_A_MASK) == PSM_LINK_EN_A_MASK)
                      && link_en_b_r[PSM_LINK_EN_B_BIT];
  assign cur_mag    = psm_mag(sample_in.data);
  assign cur_peak   = (seed_r || cur_mag > run_max_r) ? cur_mag : run_max_r;
  assign period_end = enabled_r && sample_in.valid && (timer_r <= 24'h00_0001);

  // register writes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      control_r    <= PSM_REG_RESET;
      link_en_a_r  <= PSM_REG_RESET;
      link_en_b_r  <= PSM_REG_RESET;
      cbit_sel_a_r <= PSM_REG_RESET;
      cbit_sel_b_r <= PSM_REG_RESET;
      cbit_count_r <= PSM_REG_RESET;
      period_r     <= PSM_PERIOD_RESET;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        PSM_ADDR_CONTROL:    control_r <= reg_req.wdata;
        PSM_ADDR_PERIOD_LO:  period_r[7:0] <= reg_req.wdata;
        PSM_ADDR_PERIOD_MID: period_r[15:8] <= reg_req.wdata;
        PSM_ADDR_PERIOD_HI:  period_r[23:16] <= reg_req.wdata;
        PSM_ADDR_LINK_EN_A:  link_en_a_r <= reg_req.wdata;
        PSM_ADDR_LINK_EN_B:  link_en_b_r <= reg_req.wdata;
        PSM_ADDR_CBIT_SEL_A: cbit_sel_a_r <= reg_req.wdata;
        PSM_ADDR_CBIT_SEL_B: cbit_sel_b_r <= reg_req.wdata;
        PSM_ADDR_CBIT_COUNT: cbit_count_r <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // register reads, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= PSM_REG_RESET;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        PSM_ADDR_CONTROL:    reg_rdata <= control_r;
        PSM_ADDR_PERIOD_LO:  reg_rdata <= period_r[7:0];
        PSM_ADDR_PERIOD_MID: reg_rdata <= period_r[15:8];
        PSM_ADDR_PERIOD_HI:  reg_rdata <= period_r[23:16];
        PSM_ADDR_PEAK_LO:    reg_rdata <= holding_r[7:0];
        PSM_ADDR_PEAK_HI:    reg_rdata <= {3'h0, holding_r[12:8]};
        PSM_ADDR_LINK_EN_A:  reg_rdata <= link_en_a_r;
        PSM_ADDR_LINK_EN_B:  reg_rdata <= link_en_b_r;
        PSM_ADDR_CBIT_SEL_A: reg_rdata <= cbit_sel_a_r;
        PSM_ADDR_CBIT_SEL_B: reg_rdata <= cbit_sel_b_r;
        PSM_ADDR_CBIT_COUNT: reg_rdata <= cbit_count_r;
        default:             reg_rdata <= PSM_REG_RESET;
      endcase
    end
  end

  // period timer: loads on enable, counts samples, reloads at count 1
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      enabled_r <= 1'b0;
      timer_r   <= PSM_PERIOD_RESET;
    end else begin
      enabled_r <= peak_en;
      if (peak_en && !enabled_r) begin
        timer_r <= period_r;
      end else if (period_end) begin
        timer_r <= period_r;
      end else if (enabled_r && sample_in.valid) begin
        timer_r <= timer_r - 24'h00_0001;
      end
    end
  end

  // running maximum, seeded by the first sample of each period
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_max_r <= PSM_PEAK_RESET;
      seed_r    <= 1'b1;
    end else if (!enabled_r) begin
      seed_r    <= 1'b1;
    end else if (sample_in.valid) begin
      run_max_r <= cur_peak;
      seed_r    <= period_end;
    end
  end

  // holding register and its update pulse
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      holding_r   <= PSM_PEAK_RESET;
      peak_update <= 1'b0;
    end else begin
      peak_update <= period_end;
      if (period_end) begin
        holding_r <= cur_peak;
      end
    end
  end

  // serial frame: pending flag is set by a new result, set wins over the load
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_state_r      <= PSM_TX_IDLE;
      frame_pending_r <= 1'b0;
      shift_r         <= {PSM_FRAME_W{PSM_IDLE_BIT}};
      bit_cnt_r       <= 5'h00;
    end else begin
      if (period_end) begin
        frame_pending_r <= 1'b1;
      end
      if (sample_in.valid) begin
        case (tx_state_r)
          PSM_TX_IDLE: begin
            if (frame_pending_r) begin
              shift_r <= {PSM_ID_SUBFRAME,
                          PSM_START_BIT, holding_r[12:9],
                          PSM_START_BIT, holding_r[8:5],
                          PSM_START_BIT, holding_r[4:1],
                          PSM_START_BIT, holding_r[0], PSM_LSB_PAD};
              bit_cnt_r  <= 5'(PSM_FRAME_W);
              tx_state_r <= PSM_TX_SEND;
              if (!period_end) begin
                frame_pending_r <= 1'b0;
              end
            end
          end
          PSM_TX_SEND: begin
            shift_r   <= {shift_r[PSM_FRAME_W-2:0], PSM_IDLE_BIT};
            bit_cnt_r <= bit_cnt_r - 5'h01;
            if (bit_cnt_r == 5'h01) begin
              tx_state_r <= PSM_TX_IDLE;
            end
          end
          default: tx_state_r <= PSM_TX_IDLE;
        endcase
      end
    end
  end

  // current monitor bit: frame msb while sending, idle one otherwise
  assign mon_bit = (tx_state_r == PSM_TX_SEND) ? shift_r[PSM_FRAME_W-1] : PSM_IDLE_BIT;

  // monitor stream takes the most significant control bit
  assign cbits = (link_en && cbit_count_r[1:0] != 2'h0)
                 ? {mon_bit, 2'h0} : 3'h0;

  // output word: sample with control bits appended below its lsb
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      word_out <= '0;
    end else begin
      word_out.valid <= sample_in.valid;
      word_out.word  <= {sample_in.data, cbits};
    end
  end

endmodule // psm_peak_monitor

// ==== psm_peak_monitor_sva.sv ====
`timescale 1ns/100ps
module psm_chk
  import psm_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            reset,
  input wire psm_sample_type  sample_in,
  input wire psm_reg_req_type reg_req,
  input wire logic [7:0]      reg_rdata,
  input wire psm_word_type    word_out,
  input wire logic            peak_update
);
  logic [7:0] ea_r, eb_r, cs_r;
  logic [4:0] pos_r;
  logic       lk;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // shadow of the link enable and control bit count registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ea_r <= 8'h00;
      eb_r <= 8'h00;
      cs_r <= 8'h00;
    end else if (reg_req.wr) begin
      if (reg_req.addr == PSM_ADDR_LINK_EN_A) ea_r <= reg_req.wdata;
      if (reg_req.addr == PSM_ADDR_LINK_EN_B) eb_r <= reg_req.wdata;
      if (reg_req.addr == PSM_ADDR_CBIT_COUNT) cs_r <= reg_req.wdata;
    end
  end
  assign lk = ea_r[1:0] == 2'h3 && eb_r[1] && cs_r[1:0] != 2'h0;
  // bit position inside a monitor frame, 0 while idle
  always_ff @(posedge clk_sys) begin
    if (reset || !lk) pos_r <= 5'h00;
    else if (word_out.valid && (pos_r != 5'h00 || !word_out.word[2]))
      pos_r <= (pos_r == 5'h18) ? 5'h00 : pos_r + 5'h01;
  end
  a_valid_follows: assert property (sample_in.valid |=> word_out.valid)
    else $error("word valid missing");
  a_data_copied: assert property (
    sample_in.valid |=> word_out.word[16:3] == $past(sample_in.data))
    else $error("sample not copied");
  a_low_cbits: assert property (word_out.valid |-> word_out.word[1:0] == 2'h0)
    else $error("lower control bits set");
  a_update_cause: assert property (
    peak_update |-> $past(sample_in.valid) || $past(sample_in.valid, 2))
    else $error("update without sample");
  a_reset_clears: assert property (disable iff (1'b0)
    reset |=> word_out == '0 && !peak_update && reg_rdata == 8'h00)
    else $error("reset did not clear");
  a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_link_off: assert property (
    !lk && !$past(lk) && word_out.valid |-> !word_out.word[2])
    else $error("monitor bit while link off");
  a_frame_id: assert property (
    word_out.valid && pos_r inside {[5'h01:5'h04]} |-> word_out.word[2] == (pos_r == 5'h04))
    else $error("bad identifier");
endmodule // psm_chk

bind psm_peak_monitor psm_chk u_chk (.clk_sys, .reset, .sample_in, .reg_req, .reg_rdata,
  .word_out, .peak_update);

// ==== psm_link_rx.sv ====
`timescale 1ns/100ps
module psm_link_rx
  import psm_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire psm_word_type word_out,
  output logic              frame_done,
  output logic              frame_ok,
  output logic [12:0]       frame_peak
);
  logic [24:0] sr_r;
  logic [4:0]  n_r;
  // gather msb-first bits from the top control position
  always_ff @(posedge clk_sys) begin
    frame_done <= 1'b0;
    if (reset) begin
      n_r <= 5'h00;
    end else if (word_out.valid && (n_r != 5'h00 || !word_out.word[2])) begin
      sr_r <= {sr_r[23:0], word_out.word[2]};
      n_r <= (n_r == 5'h18) ? 5'h00 : n_r + 5'h01;
      frame_done <= (n_r == 5'h18);
    end
  end
  // start bits, identifier and pad must match
  assign frame_ok = sr_r[24:20] == PSM_ID_SUBFRAME && !sr_r[19] && !sr_r[14] && !sr_r[9]
    && !sr_r[4] && sr_r[2:0] == PSM_LSB_PAD;
  assign frame_peak = {sr_r[18:15], sr_r[13:10], sr_r[8:5], sr_r[3]};
endmodule // psm_link_rx

// ==== psm_peak_monitor_tb_top.sv ====
`timescale 1ns/100ps
module psm_peak_monitor_tb_top
  import psm_pkg::*;
;
  localparam int PER = 30;
  logic            clk_sys = 1'b0;
  logic            reset = 1'b1;
  psm_sample_type  sample_in = '0;
  psm_reg_req_type reg_req = '0;
  logic [7:0]      reg_rdata;
  psm_word_type    word_out;
  logic            peak_update, frame_done, frame_ok, link_on = 1'b1;
  logic [12:0]     frame_peak, last_pk, hold_pk;
  logic [14:0]     word_q[$];
  logic [12:0]     peak_q[$];
  int              failures = 0, samples_checked = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  psm_peak_monitor dut (.clk_sys, .reset, .sample_in, .reg_req, .reg_rdata, .word_out,
    .peak_update);
  psm_link_rx rx (.clk_sys, .reset, .word_out, .frame_done, .frame_ok, .frame_peak);
  task automatic fail(input string m);
    failures++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_reg(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e) fail("register read");
  endtask
  task automatic cmp_word(input logic [16:0] g, input logic [14:0] e);
    samples_checked++;
    if (g[16:3] !== e[14:1] || g[1:0] !== 2'h0 || (!e[0] && g[2] !== 1'b0)) fail("word");
  endtask
  task automatic cmp_frame(input logic ok, input logic [12:0] g, e);
    samples_checked++;
    if (ok !== 1'b1 || g !== e) fail("frame");
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1 cmp_reg(reg_rdata, e);
  endtask
  // drive n samples back to back, noting words and period peaks
  task automatic run(input int n, input bit keep);
    logic [13:0] d;
    logic [12:0] m;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      d = (i == PER) ? 14'h2000 : 14'($urandom);
      sample_in <= '{valid: 1'b1, data: d};
      word_q.push_back({d, link_on});
      m = d[13] ? ((d == 14'h2000) ? 13'h1fff : 13'(-d)) : d[12:0];
      last_pk = (i % PER == 0 || m > last_pk) ? m : last_pk;
      if (keep && i % PER == PER - 1) peak_q.push_back(last_pk);
      if (keep && i % PER == PER - 1) hold_pk = last_pk;
    end
    @(posedge clk_sys);
    sample_in.valid <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // take the oldest note whenever a word or a frame appears
  always @(negedge clk_sys) begin
    if (word_out.valid === 1'b1) begin
      if (word_q.size() == 0) fail("extra word");
      else cmp_word(word_out.word, word_q.pop_front());
    end
    if (frame_done === 1'b1) begin
      if (peak_q.size() == 0) fail("extra frame");
      else cmp_frame(frame_ok, frame_peak, peak_q.pop_front());
    end
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h6466));
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd(PSM_ADDR_CONTROL, PSM_REG_RESET);
    rd(PSM_ADDR_PEAK_LO, 8'h00);
    rd(12'h0300, 8'h00);
    $display("test reset values done");
    wr(PSM_ADDR_PERIOD_LO, 8'h1e);
    wr(PSM_ADDR_PERIOD_MID, 8'h00);
    wr(PSM_ADDR_PERIOD_HI, 8'h00);
    wr(PSM_ADDR_LINK_EN_A, 8'h03);
    wr(PSM_ADDR_LINK_EN_B, 8'h02);
    wr(PSM_ADDR_CBIT_SEL_A, 8'h00);
    wr(PSM_ADDR_CBIT_SEL_B, 8'h00);
    wr(PSM_ADDR_CBIT_COUNT, 8'h01);
    wr(PSM_ADDR_CONTROL, 8'h02);
    repeat (3) @(posedge clk_sys);
    run(4 * PER + 28, 1'b1);
    rd(PSM_ADDR_PEAK_LO, hold_pk[7:0]);
    rd(PSM_ADDR_PEAK_HI, {3'h0, hold_pk[12:8]});
    if (peak_q.size() != 0) fail("frame missing");
    $display("test periods and frames done");
    link_on = 1'b0;
    wr(PSM_ADDR_LINK_EN_B, 8'h00);
    run(8, 1'b0);
    repeat (3) @(posedge clk_sys);
    $display("test link disable done");
    report_and_stop();
  end
endmodule // psm_peak_monitor_tb_top
